// File: hdl/mci_down_cnt.sv
// Loadable down-counter that holds at zero
`timescale 1ns/100ps
module mci_down_cnt #(
   parameter int W = 3
) (
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output logic      [W-1:0] count
);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         count <= '0;
      end else if (load) begin
         count <= load_val;
      end else if (count != '0) begin
         count <= count - W'(1);
      end
   end
endmodule // mci_down_cnt

// File: hdl/mci_interlock.sv
// Multiplier contention interlock: stretches multiplier MAs, splits them with fetch
`timescale 1ns/100ps
`include "mci_regs.svh"
module mci_interlock (
   input  wire logic                 core_clk,
   input  wire logic                 sys_rst,
   input  wire logic                 later_core,
   input  wire mci_pkg::mci_dec_type dec_in,
   input  wire mci_pkg::mci_ma_type  ma_in,
   input  wire logic                 if_req,
   output logic                      ma_grant_r,
   output logic                      if_grant_r,
   output logic                      id_stall_r,
   output logic                      mult_busy_r,
   output logic                      ma_stretch_r
);
   // ----------------------------------------
   // Busy counter and separation tracking
   // ----------------------------------------
   logic [`MCI_CNT_W-1:0] cnt;
   logic [`MCI_CNT_W-1:0] load_val;
   logic                  load;
   logic                  busy;
   logic                  just_ended_r;
   logic                  waited_r;
   logic                  long_src_r;
   logic [`MCI_SEP_W-1:0] sep_r;
   logic [`MCI_SEP_W-1:0] cons_sep_r;
   logic                  dec_mac;
   logic                  dec_user;
   logic                  hold;
   logic                  ma_ok;
   mci_pkg::mci_arb_type  st_r;
   mci_pkg::mci_arb_type  st_nxt;

   assign busy = (cnt != '0);
   assign dec_mac = dec_in.valid && (dec_in.kind == mci_pkg::MCI_OP_WORD_MAC
                                     || dec_in.kind == mci_pkg::MCI_OP_LONG_MAC);
   assign dec_user = dec_in.valid && (dec_in.kind != mci_pkg::MCI_OP_OTHER);

   // Final MA of a MAC starts the busy window
   assign load = ma_grant_r && ma_in.second
                 && (ma_in.kind == mci_pkg::MCI_OP_WORD_MAC || ma_in.kind == mci_pkg::MCI_OP_LONG_MAC);
   assign load_val = (ma_in.kind == mci_pkg::MCI_OP_LONG_MAC) ? `MCI_LONG_BUSY
                                                               : `MCI_WORD_BUSY;

   mci_down_cnt #(
      .W        (`MCI_CNT_W)
   ) u_busy_cnt (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .load     (load),
      .load_val (load_val),
      .count    (cnt)
   );

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mult_busy_r <= 1'b0;
      end else begin
         mult_busy_r <= load || (cnt > `MCI_CNT_W'(1));
      end
   end

   // Marks the first idle state after a busy window
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         just_ended_r <= 1'b0;
      end else begin
         just_ended_r <= !load && (cnt == `MCI_CNT_W'(1));
      end
   end

   // Which kind of MAC opened the current busy window
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         long_src_r <= 1'b0;
      end else if (load) begin
         long_src_r <= (ma_in.kind == mci_pkg::MCI_OP_LONG_MAC);
      end
   end

   // Count unrelated decodes since the last MAC; saturates
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sep_r <= `MCI_SEP_RESET;
      end else if (dec_mac) begin
         sep_r <= '0;
      end else if (dec_in.valid && !dec_user && sep_r != `MCI_SEP_RESET) begin
         sep_r <= sep_r + `MCI_SEP_W'(1);
      end
   end

   // Latch the gap at consumer decode so later decodes cannot widen it
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cons_sep_r <= `MCI_SEP_RESET;
      end else if (dec_user) begin
         cons_sep_r <= sep_r;
      end
   end

   // ----------------------------------------
   // Decode stall
   // ----------------------------------------
   // Exactly one slot; afterwards the pipeline runs as if the MAC had five stages
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         id_stall_r <= 1'b0;
      end else begin
         id_stall_r <= dec_mac;
      end
   end

   // ----------------------------------------
   // Contention decision
   // ----------------------------------------
   always_comb begin
      hold = 1'b0;
      case (ma_in.kind)
         mci_pkg::MCI_OP_WORD_MAC: begin
            // Later core: second MA never waits
            hold = ma_in.second && !later_core && busy
                   && (cons_sep_r < `MCI_SEP_MAC);
         end
         mci_pkg::MCI_OP_LONG_MAC: begin
            // Later core: a word MAC's busy window never delays it
            hold = ma_in.second && busy && (cons_sep_r < `MCI_SEP_MUL)
                   && !(later_core && !long_src_r);
         end
         mci_pkg::MCI_OP_WORD_MUL: begin
            hold = busy && (later_core ? (cons_sep_r < `MCI_SEP_MAC)
                                       : (cons_sep_r < `MCI_SEP_MUL));
         end
         mci_pkg::MCI_OP_DBL_MUL: begin
            hold = !later_core && busy && (cons_sep_r < `MCI_SEP_MUL);
         end
         mci_pkg::MCI_OP_STS_MEM: begin
            hold = busy || (waited_r && just_ended_r);
         end
         mci_pkg::MCI_OP_STS_REG: begin
            hold = busy;
         end
         mci_pkg::MCI_OP_LDS_REG: begin
            hold = busy;
         end
         mci_pkg::MCI_OP_LDS_MEM: begin
            hold = busy;
         end
         default: begin
            hold = 1'b0;
         end
      endcase
   end

   assign ma_ok = ma_in.req && !ma_grant_r;

   // ----------------------------------------
   // Bus arbiter: MA first, fetch takes the split-off half
   // ----------------------------------------
   // A stretched MA keeps the bus, so fetch is deferred rather than interleaved
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         mci_pkg::MCI_ARB_IDLE: begin
            if (ma_ok && hold) begin
               st_nxt = mci_pkg::MCI_ARB_STRETCH;
            end else if (ma_ok && if_req && !if_grant_r) begin
               st_nxt = mci_pkg::MCI_ARB_SPLIT;
            end
         end
         mci_pkg::MCI_ARB_STRETCH: begin
            if (!ma_in.req) begin
               st_nxt = mci_pkg::MCI_ARB_IDLE;
            end else if (!hold) begin
               st_nxt = if_req ? mci_pkg::MCI_ARB_SPLIT : mci_pkg::MCI_ARB_IDLE;
            end
         end
         mci_pkg::MCI_ARB_SPLIT: begin
            st_nxt = mci_pkg::MCI_ARB_IDLE;
         end
         default: begin
            st_nxt = mci_pkg::MCI_ARB_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_r <= mci_pkg::MCI_ARB_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ma_grant_r <= 1'b0;
      end else begin
         ma_grant_r <= ma_ok && !hold && (st_r != mci_pkg::MCI_ARB_SPLIT);
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         if_grant_r <= 1'b0;
      end else if (st_r == mci_pkg::MCI_ARB_SPLIT) begin
         if_grant_r <= if_req;
      end else begin
         if_grant_r <= if_req && !if_grant_r && !ma_ok && st_r == mci_pkg::MCI_ARB_IDLE;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ma_stretch_r <= 1'b0;
      end else begin
         ma_stretch_r <= ma_ok && hold;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         waited_r <= 1'b0;
      end else begin
         waited_r <= ma_ok && busy;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking mci_cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   word_busy_len_a: assert property ((load && ma_in.kind == mci_pkg::MCI_OP_WORD_MAC) |=>
      mult_busy_r ##1 (mult_busy_r || load) ##1 (!mult_busy_r || $past(load) || $past(load, 2)))
      else $error("word MAC busy window wrong");

   long_busy_len_a: assert property ((load && ma_in.kind == mci_pkg::MCI_OP_LONG_MAC) |=>
      (cnt == `MCI_LONG_BUSY) ##1 (mult_busy_r || load))
      else $error("long MAC busy window wrong");

   mac_stretch_a: assert property ((ma_ok && ma_in.kind == mci_pkg::MCI_OP_WORD_MAC && ma_in.second
      && !later_core && busy && cons_sep_r == '0) |=> !ma_grant_r)
      else $error("early word MAC granted while busy");

   mac_gap_a: assert property ((st_r == mci_pkg::MCI_ARB_IDLE && ma_ok
      && ma_in.kind == mci_pkg::MCI_OP_WORD_MAC && !later_core && cons_sep_r != '0) |=> ma_grant_r)
      else $error("word MAC stalled despite gap");

   later_mac_a: assert property ((st_r == mci_pkg::MCI_ARB_IDLE && ma_ok && later_core
      && ma_in.kind == mci_pkg::MCI_OP_WORD_MAC) |=> ma_grant_r)
      else $error("later word MAC waited");

   split_order_a: assert property ((st_r == mci_pkg::MCI_ARB_IDLE && ma_ok && !hold
      && if_req && !if_grant_r) |=> ma_grant_r ##1 (if_grant_r || !$past(if_req)))
      else $error("fetch split order wrong");

   store_mem_extra_a: assert property ((ma_ok && ma_in.kind == mci_pkg::MCI_OP_STS_MEM
      && waited_r && just_ended_r) |=> !ma_grant_r)
      else $error("memory store skipped extra state");

   lds_wait_a: assert property ((ma_ok && busy && (ma_in.kind == mci_pkg::MCI_OP_LDS_REG
      || ma_in.kind == mci_pkg::MCI_OP_LDS_MEM)) |=> !ma_grant_r)
      else $error("accumulator load granted while busy");

   dbl_later_a: assert property ((st_r == mci_pkg::MCI_ARB_IDLE && ma_ok && later_core
      && ma_in.kind == mci_pkg::MCI_OP_DBL_MUL) |=> ma_grant_r)
      else $error("later double multiply waited");

   id_stall_one_a: assert property ((dec_mac) |=> id_stall_r ##1 (!id_stall_r || $past(dec_mac)))
      else $error("decode stall not one slot");

   grant_excl_a: assert property (!(ma_grant_r && if_grant_r))
      else $error("both grants at once");

   // ----------------------------------------
   // Counter, arbiter and decode stall checks
   // ----------------------------------------
   word_load_a: assert property ((load && ma_in.kind == mci_pkg::MCI_OP_WORD_MAC) |=>
      (cnt == `MCI_WORD_BUSY))
      else $error("word MAC busy count not loaded");

   count_step_a: assert property ((busy && !load) |=>
      (cnt == $past(cnt) - `MCI_CNT_W'(1)))
      else $error("busy counter did not step down");

   busy_idle_a: assert property ((!busy && !load) |=> !mult_busy_r)
      else $error("busy flag without a window");

   mul_stretch_a: assert property ((ma_ok && ma_in.kind == mci_pkg::MCI_OP_WORD_MUL && !later_core
      && busy && cons_sep_r < `MCI_SEP_MUL) |=> !ma_grant_r)
      else $error("early word multiply granted while busy");

   mul_gap_a: assert property ((st_r == mci_pkg::MCI_ARB_IDLE && ma_ok && !later_core
      && ma_in.kind == mci_pkg::MCI_OP_WORD_MUL && cons_sep_r >= `MCI_SEP_MUL) |=> ma_grant_r)
      else $error("word multiply stalled despite gap");

   later_mul_a: assert property ((ma_ok && later_core && ma_in.kind == mci_pkg::MCI_OP_WORD_MUL
      && busy && cons_sep_r == '0) |=> !ma_grant_r)
      else $error("adjacent later multiply not held");

   sts_reg_wait_a: assert property ((ma_ok && busy && ma_in.kind == mci_pkg::MCI_OP_STS_REG)
      |=> !ma_grant_r)
      else $error("accumulator store granted while busy");

   sts_mem_wait_a: assert property ((ma_ok && busy && ma_in.kind == mci_pkg::MCI_OP_STS_MEM)
      |=> !ma_grant_r)
      else $error("memory store granted while busy");

   later_long_a: assert property ((st_r == mci_pkg::MCI_ARB_IDLE && ma_ok && later_core
      && ma_in.kind == mci_pkg::MCI_OP_LONG_MAC && !long_src_r) |=> ma_grant_r)
      else $error("long MAC waited on word MAC window");

   stretch_end_a: assert property ((st_r == mci_pkg::MCI_ARB_STRETCH && ma_in.req && !hold)
      |=> ma_grant_r)
      else $error("stretched MA not released");

   fetch_defer_a: assert property ((st_r == mci_pkg::MCI_ARB_STRETCH) |=> !if_grant_r)
      else $error("fetch granted during stretched MA");

   ma_first_a: assert property ((st_r == mci_pkg::MCI_ARB_IDLE && ma_ok && if_req) |=> !if_grant_r)
      else $error("fetch won over MA");

   split_fetch_a: assert property ((st_r == mci_pkg::MCI_ARB_SPLIT && if_req) |=> if_grant_r)
      else $error("split slot not given to fetch");

   stall_only_mac_a: assert property (!dec_mac |=> !id_stall_r)
      else $error("decode stalled after unrelated op");

   // ----------------------------------------
   // Cover points
   // ----------------------------------------
   // Scenarios worth seeing at least once
   stretch_c: cover property (ma_stretch_r ##1 ma_stretch_r ##1 ma_grant_r);
   sts_extra_c: cover property (ma_ok && ma_in.kind == mci_pkg::MCI_OP_STS_MEM && waited_r && just_ended_r);
   later_split_c: cover property (later_core && st_r == mci_pkg::MCI_ARB_SPLIT);
   split_c: cover property (ma_grant_r ##1 if_grant_r);
   later_mul_c: cover property (later_core && ma_ok && ma_in.kind == mci_pkg::MCI_OP_WORD_MUL && hold);
endmodule // mci_interlock

// File: hdl/mci_pkg.sv
// Types shared by the multiplier contention interlock
package mci_pkg;
   typedef enum logic [3:0] {
      MCI_OP_OTHER    = 4'h0,
      MCI_OP_WORD_MAC = 4'h1,
      MCI_OP_LONG_MAC = 4'h2,
      MCI_OP_WORD_MUL = 4'h3,
      MCI_OP_DBL_MUL  = 4'h4,
      MCI_OP_STS_REG  = 4'h5,
      MCI_OP_STS_MEM  = 4'h6,
      MCI_OP_LDS_REG  = 4'h7,
      MCI_OP_LDS_MEM  = 4'h8
   } mci_op_type;

   typedef enum logic [2:0] {
      MCI_ARB_IDLE    = 3'b001,
      MCI_ARB_STRETCH = 3'b010,
      MCI_ARB_SPLIT   = 3'b100
   } mci_arb_type;

   typedef struct packed {
      logic       valid;
      mci_op_type kind;
   } mci_dec_type;

   typedef struct packed {
      logic       req;
      mci_op_type kind;
      logic       second;
   } mci_ma_type;
endpackage

// File: hdl/mci_regs.svh
// Constants for the multiplier contention interlock
// Functional notes
// - Early word MAC: busy two cycles after MA
// - Early word MAC second MA stretches while busy
// - Early: one unrelated op between MACs, no stall
// - Stretched word MAC MA splits with fetch
// - Early word multiply MA stretches while busy
// - Early: two unrelated ops before multiply, no stall
// - Accumulator store to register waits out busy
// - Accumulator store to memory waits one extra state
// - Accumulator load from register waits out busy
// - Accumulator load from memory waits out busy
// - Long MAC: two MAs then four busy stages
// - Long MAC: busy four cycles after MA
// - Decode after long MAC stalls one slot
// - Unrelated op after long MAC: only decode stall
// - Long MAC MAs split with fetch on collision
// - Later word MAC second MA never waits
// - Later word MAC MA splits with fetch
// - Later multiply waits only when directly adjacent
// - Later double multiply never waits on busy
`ifndef MCI_REGS_SVH
`define MCI_REGS_SVH
`define MCI_CNT_W       3
`define MCI_SEP_W       2
`define MCI_WORD_BUSY   3'h2
`define MCI_LONG_BUSY   3'h4
`define MCI_SEP_RESET   2'h3
`define MCI_SEP_MAC     2'h1
`define MCI_SEP_MUL     2'h2
`endif

// File: verification/multiplier_contention_interlock_test.sv
// Self-checking bench for the multiplier contention interlock
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin bad_count++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module multiplier_contention_interlock_test;
   // ----------------------------------------
   // Signals and stimulus table
   // ----------------------------------------
   localparam mci_pkg::mci_op_type op_ot = mci_pkg::MCI_OP_OTHER;
   localparam mci_pkg::mci_op_type op_wm = mci_pkg::MCI_OP_WORD_MAC;
   localparam mci_pkg::mci_op_type op_lm = mci_pkg::MCI_OP_LONG_MAC;
   localparam mci_pkg::mci_op_type op_mu = mci_pkg::MCI_OP_WORD_MUL;
   typedef struct packed {
      logic               later;
      mci_pkg::mci_op_type pk;
      logic [1:0]         gap;
      mci_pkg::mci_op_type ck;
      logic               csec;
      logic               fi;
      logic               held;
   } mci_row_type;
   logic                 core_clk;
   logic                 sys_rst;
   logic                 later_core;
   mci_pkg::mci_dec_type dec_in;
   mci_pkg::mci_ma_type  ma_in;
   logic                 if_req;
   logic                 ma_grant_r;
   logic                 if_grant_r;
   logic                 id_stall_r;
   logic                 mult_busy_r;
   logic                 ma_stretch_r;
   int                   bad_count = 0;
   int                   compares = 0;
   int                   lats[15];
   // Producer decode and MA, gap of unrelated decodes, then the dependent MA
   mci_row_type rows[15] = '{
      '{0, op_wm, 0, op_wm, 1, 1, 1},
      '{0, op_wm, 1, op_wm, 1, 0, 0},
      '{0, op_wm, 1, op_mu, 0, 0, 1},
      '{0, op_wm, 2, op_mu, 0, 0, 0},
      '{0, op_wm, 0, mci_pkg::MCI_OP_STS_REG, 0, 0, 1},
      '{0, op_wm, 0, mci_pkg::MCI_OP_STS_MEM, 0, 0, 1},
      '{0, op_wm, 0, mci_pkg::MCI_OP_LDS_REG, 0, 0, 1},
      '{0, op_wm, 0, mci_pkg::MCI_OP_LDS_MEM, 0, 0, 1},
      '{0, op_lm, 0, op_wm, 1, 1, 1},
      '{0, op_lm, 2, op_wm, 1, 0, 0},
      '{1, op_wm, 0, op_wm, 1, 1, 0},
      '{1, op_wm, 0, op_lm, 1, 0, 0},
      '{1, op_wm, 0, op_mu, 0, 0, 1},
      '{1, op_wm, 1, op_mu, 0, 0, 0},
      '{1, op_wm, 0, mci_pkg::MCI_OP_DBL_MUL, 0, 0, 0}
   };
   mci_interlock mci_interlock_inst (
      .core_clk     (core_clk),
      .sys_rst      (sys_rst),
      .later_core   (later_core),
      .dec_in       (dec_in),
      .ma_in        (ma_in),
      .if_req       (if_req),
      .ma_grant_r   (ma_grant_r),
      .if_grant_r   (if_grant_r),
      .id_stall_r   (id_stall_r),
      .mult_busy_r  (mult_busy_r),
      .ma_stretch_r (ma_stretch_r)
   );
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic conclude();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // One decode pulse; stall must cover exactly the next slot after a MAC
   task automatic dec(input mci_pkg::mci_op_type k);
      @(negedge core_clk);
      dec_in = {1'b1, k};
      @(negedge core_clk);
      dec_in = {1'b0, op_ot};
      `CHK("id_stall", (k == op_wm || k == op_lm), id_stall_r)
      @(negedge core_clk);
      `CHK("id_stall_end", 1'b0, id_stall_r)
   endtask
   // Producer final MA, then either a busy count or an adjacent dependent MA
   task automatic pair(input mci_pkg::mci_op_type pk, input mci_pkg::mci_op_type ck, input logic csec,
                       input logic two, input logic fi, output int lat, output logic st,
                       output int fl, output int bsy);
      int   i;
      logic gp;
      ma_in = {1'b1, pk, 1'b1};
      lat = 0;
      st = 0;
      fl = 0;
      bsy = 0;
      gp = 0;
      for (i = 0; i < 20 && !gp; i++) begin
         @(negedge core_clk);
         gp = (ma_grant_r === 1'b1);
      end
      // The producer request stands through its grant cycle so the window loads
      @(negedge core_clk);
      if (!two) begin
         ma_in = {1'b0, pk, 1'b1};
         for (i = 0; i < 10; i++) begin
            bsy += (mult_busy_r === 1'b1);
            @(negedge core_clk);
         end
      end else begin
         // Swap straight to the dependent request so it meets the busy window
         ma_in = {1'b1, ck, csec};
         if_req = fi;
         gp = 0;
         for (i = 1; i <= 20 && !gp; i++) begin
            @(negedge core_clk);
            if (ma_stretch_r === 1'b1) st = 1;
            if (if_grant_r === 1'b1 && fl == 0) fl = i;
            gp = (ma_grant_r === 1'b1);
            lat = i;
         end
         @(negedge core_clk);
         if (if_grant_r === 1'b1 && fl == 0) fl = lat + 1;
         ma_in = {1'b0, ck, csec};
         for (i = lat + 2; i <= lat + 4 && fl == 0 && fi; i++) begin
            @(negedge core_clk);
            if (if_grant_r === 1'b1) fl = i;
         end
         @(negedge core_clk);
         if_req = 0;
      end
      `CHK("ma_grant", 1'b1, gp)
   endtask
   // ----------------------------------------
   // Clock, watchdog and main sequence
   // ----------------------------------------
   initial begin
      core_clk = 0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Roughly 400 cycles expected; allow over twelve times that
   initial begin
      #25000;
      bad_count++;
      conclude();
   end
   initial begin
      int   r;
      int   lat;
      int   fl;
      int   bsy;
      logic st;
      sys_rst = 1;
      later_core = 0;
      dec_in = {1'b0, op_ot};
      ma_in = {1'b0, op_ot, 1'b0};
      if_req = 0;
      repeat (8) @(negedge core_clk);
      `CHK("rst_out", 5'h0, {ma_grant_r, if_grant_r, id_stall_r, mult_busy_r, ma_stretch_r})
      sys_rst = 0;
      for (r = 0; r < 15; r++) begin
         later_core = rows[r].later;
         dec(rows[r].pk);
         repeat (rows[r].gap) dec(op_ot);
         dec(rows[r].ck);
         pair(rows[r].pk, rows[r].ck, rows[r].csec, 1, rows[r].fi, lat, st, fl, bsy);
         `CHK("held", rows[r].held, st)
         if (rows[r].fi) `CHK("fetch_split", lat + 1, fl)
         lats[r] = lat;
         repeat (10) @(negedge core_clk);
      end
      `CHK("sts_mem_extra", lats[4] + 1, lats[5])
      later_core = 0;
      pair(op_wm, op_ot, 0, 0, 0, lat, st, fl, bsy);
      `CHK("word_busy", 2, bsy)
      pair(op_lm, op_ot, 0, 0, 0, lat, st, fl, bsy);
      `CHK("long_busy", 4, bsy)
      // Reset in mid busy window must clear it at once
      ma_in = {1'b1, op_lm, 1'b1};
      repeat (2) @(negedge core_clk);
      `CHK("pre_rst_busy", 1'b1, mult_busy_r)
      ma_in = {1'b0, op_lm, 1'b1};
      sys_rst = 1;
      @(negedge core_clk);
      `CHK("mid_rst", 2'h0, {mult_busy_r, ma_stretch_r})
      @(negedge core_clk);
      sys_rst = 0;
      // The window must restart cleanly right after release
      pair(op_wm, op_ot, 0, 0, 0, lat, st, fl, bsy);
      `CHK("rst_word_busy", 2, bsy)
      conclude();
   end
endmodule // multiplier_contention_interlock_test
